// >>> design/cboc_interval.sv
// Purpose: interval counter, pulses once every LIMIT cycles while run
// Assumes: run_i is synchronous to clk_sys_i
// Notes:   dropping run_i restarts the count from zero
`timescale 1ns/1ns
`include "cboc_params.svh"

module cboc_interval #(
	parameter int unsigned LIMIT = 800
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic run_i,
	output logic expired_o
);

	localparam logic [`CBOC_TIMER_W-1:0] LAST = `CBOC_TIMER_W'(LIMIT - 1);

	cboc_pkg::cboc_interval_state_t st_reg;
	cboc_pkg::cboc_interval_state_t st_next;

	// ----------------------------------------
	// count
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.expired = 1'b0;
		if (!run_i) begin
			st_next.count = '0;
		end else if (st_reg.count >= LAST) begin
			st_next.count = '0;
			st_next.expired = 1'b1;
		end else begin
			st_next.count = st_reg.count + `CBOC_TIMER_W'(1);
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign expired_o = st_reg.expired;

endmodule : cboc_interval

// >>> design/cboc_option_bank.sv
// Purpose: option register bank of a battery charge controller
// Assumes: serial word transport decoded upstream into one-cycle requests
// Notes:   protection and mode controls are registered outputs
`timescale 1ns/1ns
`include "cboc_params.svh"

// Functional notes
// (RQ1) limit is programmed value, or lower with pin
// (RQ2) monitor shows discharge at 0, charge at 1
// (RQ3) low-side switch threshold 210 mV or 150 mV
// (RQ4) fixed input trip stops converter, auto resume
// (RQ5) configurable trip after blank-out, 250ms release deglitch
// (RQ6) configurable level 133% or 200%
// (RQ7) discharge overcurrent disables converter when enabled
// (RQ8) discharge level 133% or 200% of threshold
// (RQ9) high impedance bit selects minimal current operation
// (RQ10) register reset restores defaults, then self-clears
// (RQ11) remeasure stops converter until measurement done
// (RQ12) bus supply needs enable bit and pin
// (RQ13) current optimizer runs only while enabled
// (RQ14) switch drive pin released at 0, driven at 1
// (RQ15) soft slew steps minimum voltage every 8us
// (RQ16) third option register resets to 0434h
// (RQ17) word access, self-clearing bits read back zero; the remeasure bit reads back one until measure_done clears it
module cboc_option_bank #(
	parameter int unsigned ACOC_BLANK_CYC = `CBOC_ACOC_BLANK_CYC,
	parameter int unsigned ACOC_RELEASE_CYC = `CBOC_ACOC_RELEASE_CYC
) (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire cboc_pkg::cboc_host_req_t host_req_i,
	input wire cboc_pkg::cboc_sense_t sense_i,
	output logic [15:0] rdata_o,
	output logic rd_ack_o,
	output logic [7:0] input_limit_o,
	output logic [7:0] battery_current_monitor_out_o,
	output logic [8:0] low_side_oc_mv_o,
	output logic [8:0] fixed_input_oc_mv_o,
	output logic [7:0] config_input_oc_pct_o,
	output logic converter_enable_o,
	output logic config_input_oc_fault_o,
	output logic discharge_oc_fault_o,
	output logic high_impedance_mode_o,
	output logic register_reset_pulse_o,
	output logic remeasure_active_o,
	output logic bus_supply_mode_o,
	output logic current_optimizer_run_o,
	output logic battery_switch_drive_o,
	output logic battery_switch_drive_oe_n_o,
	output logic [7:0] min_system_voltage_o
);

	localparam int unsigned TIMER_LIMIT [3] = '{
		ACOC_BLANK_CYC, ACOC_RELEASE_CYC, `CBOC_SLEW_STEP_CYC
	};

	cboc_pkg::cboc_bank_state_t st_reg;
	cboc_pkg::cboc_bank_state_t st_next;
	logic [2:0] timer_run;
	logic [2:0] timer_expired;
	logic [15:0] dchg_limit;

	function automatic logic reg_hit(input logic [7:0] cmd, input logic [7:0] addr);
		return cmd == addr;
	endfunction : reg_hit

	// ----------------------------------------
	// interval timers: blank-out, release, slew step
	// ----------------------------------------
	assign timer_run[0] = (st_reg.acoc == cboc_pkg::CBOC_ACOC_BLANK) &&
		sense_i.config_input_oc_trip;
	assign timer_run[1] = (st_reg.acoc == cboc_pkg::CBOC_ACOC_RELEASE) &&
		!sense_i.config_input_oc_trip;
	assign timer_run[2] = st_reg.opt3[`CBOC_B_SOFT_SLEW] &&
		(st_reg.min_sys != sense_i.min_system_voltage);

	for (genvar i = 0; i < 3; i++) begin : g_timer
		cboc_interval #(
			.LIMIT(TIMER_LIMIT[i])
		) u_interval (
			.clk_sys_i(clk_sys_i),
			.sys_rst_i(sys_rst_i),
			.run_i(timer_run[i]),
			.expired_o(timer_expired[i])
		);
	end

	// ----------------------------------------
	// discharge trip level
	// ----------------------------------------
	always_comb begin
		if (st_reg.opt2[`CBOC_B_DCHG_OC_LVL]) begin
			dchg_limit = {7'h00, sense_i.second_discharge_threshold, 1'b0}; // RQ8
		end else begin
			dchg_limit = ({8'h00, sense_i.second_discharge_threshold} *
				{8'h00, `CBOC_PCT_LOW}) / `CBOC_PCT_DIVISOR; // RQ8
		end
	end

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.rd_ack = 1'b0;
		st_next.reg_reset_pulse = 1'b0;

		// register reads
		if (host_req_i.rd) begin
			st_next.rd_ack = 1'b1;
			if (reg_hit(host_req_i.cmd, `CBOC_ADDR_OPT2)) begin
				st_next.rdata = {8'h00, st_reg.opt2}; // RQ17
			end else if (reg_hit(host_req_i.cmd, `CBOC_ADDR_OPT3)) begin
				st_next.rdata = st_reg.opt3; // RQ17
			end else begin
				st_next.rdata = 16'h0000;
			end
		end

		// measurement done clears the remeasure bit
		if (st_reg.opt3[`CBOC_B_REMEASURE] && sense_i.measure_done) begin
			st_next.opt3[`CBOC_B_REMEASURE] = 1'b0; // RQ11
		end

		// register writes, a write wins over the hardware clear
		if (host_req_i.wr && reg_hit(host_req_i.cmd, `CBOC_ADDR_OPT2)) begin
			st_next.opt2 = host_req_i.wdata[7:0];
		end
		if (host_req_i.wr && reg_hit(host_req_i.cmd, `CBOC_ADDR_OPT3)) begin
			st_next.opt3 = host_req_i.wdata;
			st_next.opt3[`CBOC_B_REG_RESET] = 1'b0; // RQ10
			if (host_req_i.wdata[`CBOC_B_REG_RESET]) begin
				st_next.opt2 = `CBOC_OPT2_RESET; // RQ10
				st_next.opt3 = `CBOC_OPT3_RESET; // RQ16
				st_next.reg_reset_pulse = 1'b1; // RQ10
			end
		end

		// configurable input overcurrent
		if (!st_reg.opt2[`CBOC_B_CFG_IN_OC_EN]) begin
			st_next.acoc = cboc_pkg::CBOC_ACOC_IDLE; // RQ5
		end else begin
			unique case (st_reg.acoc)
				cboc_pkg::CBOC_ACOC_IDLE: begin
					if (sense_i.config_input_oc_trip) begin
						st_next.acoc = cboc_pkg::CBOC_ACOC_BLANK;
					end
				end
				cboc_pkg::CBOC_ACOC_BLANK: begin
					if (!sense_i.config_input_oc_trip) begin
						st_next.acoc = cboc_pkg::CBOC_ACOC_IDLE;
					end else if (timer_expired[0]) begin
						st_next.acoc = cboc_pkg::CBOC_ACOC_FAULT; // RQ5
					end
				end
				cboc_pkg::CBOC_ACOC_FAULT: begin
					if (!sense_i.config_input_oc_trip) begin
						st_next.acoc = cboc_pkg::CBOC_ACOC_RELEASE;
					end
				end
				cboc_pkg::CBOC_ACOC_RELEASE: begin
					if (sense_i.config_input_oc_trip) begin
						st_next.acoc = cboc_pkg::CBOC_ACOC_FAULT;
					end else if (timer_expired[1]) begin
						st_next.acoc = cboc_pkg::CBOC_ACOC_IDLE; // RQ5
					end
				end
			endcase
		end
		st_next.cfg_fault = (st_next.acoc == cboc_pkg::CBOC_ACOC_FAULT) ||
			(st_next.acoc == cboc_pkg::CBOC_ACOC_RELEASE); // RQ5

		// battery discharge overcurrent
		st_next.dchg_fault = st_reg.opt2[`CBOC_B_DCHG_OC_EN] &&
			({8'h00, sense_i.discharge_current} > dchg_limit); // RQ7

		// converter run permission
		st_next.converter_en = !(st_reg.opt3[`CBOC_B_HIGH_IMP] || // RQ9
			sense_i.fixed_input_oc_trip || // RQ4
			st_next.cfg_fault || st_next.dchg_fault || // RQ7
			st_reg.opt3[`CBOC_B_REMEASURE]); // RQ11

		// input current limit source
		if (st_reg.opt2[`CBOC_B_LIMIT_PIN_SEL] &&
			(sense_i.external_limit_pin < sense_i.programmed_input_limit)) begin
			st_next.input_limit = sense_i.external_limit_pin; // RQ1
		end else begin
			st_next.input_limit = sense_i.programmed_input_limit; // RQ1
		end

		// current monitor polarity
		st_next.monitor = st_reg.opt2[`CBOC_B_MONITOR_POL] ?
			sense_i.charge_current : sense_i.discharge_current; // RQ2

		// threshold selections
		st_next.low_side_mv = st_reg.opt2[`CBOC_B_LOW_SIDE_OC] ?
			`CBOC_LOW_SIDE_OC_LO_MV : `CBOC_LOW_SIDE_OC_HI_MV; // RQ3
		if (sense_i.input_sense_resistor_select) begin
			st_next.fixed_mv = st_reg.opt2[`CBOC_B_FIXED_IN_OC] ?
				`CBOC_FIXED_OC_ALT_LO_MV : `CBOC_FIXED_OC_ALT_HI_MV; // RQ4
		end else begin
			st_next.fixed_mv = st_reg.opt2[`CBOC_B_FIXED_IN_OC] ?
				`CBOC_FIXED_OC_LO_MV : `CBOC_FIXED_OC_HI_MV; // RQ4
		end
		st_next.cfg_pct = st_reg.opt2[`CBOC_B_CFG_IN_OC_LVL] ?
			`CBOC_PCT_HIGH : `CBOC_PCT_LOW; // RQ6

		// mode outputs
		st_next.bus_supply = st_reg.opt3[`CBOC_B_BUS_SUPPLY] &&
			sense_i.shared_mode_control_pin; // RQ12
		st_next.switch_level = sense_i.battery_switch_level;
		st_next.switch_oe_n = !st_reg.opt3[`CBOC_B_SWITCH_CTRL]; // RQ14

		// minimum system voltage slew
		if (!st_reg.opt3[`CBOC_B_SOFT_SLEW]) begin
			st_next.min_sys = sense_i.min_system_voltage; // RQ15
		end else if (timer_expired[2]) begin
			if (st_reg.min_sys < sense_i.min_system_voltage) begin
				st_next.min_sys = st_reg.min_sys + 8'h01; // RQ15
			end else if (st_reg.min_sys > sense_i.min_system_voltage) begin
				st_next.min_sys = st_reg.min_sys - 8'h01; // RQ15
			end
		end
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			st_reg <= '{
				opt2: `CBOC_OPT2_RESET,
				opt3: `CBOC_OPT3_RESET, // RQ16
				acoc: cboc_pkg::CBOC_ACOC_IDLE,
				default: '0
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign rdata_o = st_reg.rdata;
	assign rd_ack_o = st_reg.rd_ack;
	assign input_limit_o = st_reg.input_limit;
	assign battery_current_monitor_out_o = st_reg.monitor;
	assign low_side_oc_mv_o = st_reg.low_side_mv;
	assign fixed_input_oc_mv_o = st_reg.fixed_mv;
	assign config_input_oc_pct_o = st_reg.cfg_pct;
	assign converter_enable_o = st_reg.converter_en;
	assign config_input_oc_fault_o = st_reg.cfg_fault;
	assign discharge_oc_fault_o = st_reg.dchg_fault;
	assign high_impedance_mode_o = st_reg.opt3[`CBOC_B_HIGH_IMP]; // RQ9
	assign register_reset_pulse_o = st_reg.reg_reset_pulse;
	assign remeasure_active_o = st_reg.opt3[`CBOC_B_REMEASURE];
	assign bus_supply_mode_o = st_reg.bus_supply;
	assign current_optimizer_run_o = st_reg.opt3[`CBOC_B_OPTIMIZER]; // RQ13
	assign battery_switch_drive_o = st_reg.switch_level;
	assign battery_switch_drive_oe_n_o = st_reg.switch_oe_n;
	assign min_system_voltage_o = st_reg.min_sys;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb_sys @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	sequence s_reset_write;
		host_req_i.wr && (host_req_i.cmd == `CBOC_ADDR_OPT3) &&
			host_req_i.wdata[`CBOC_B_REG_RESET];
	endsequence

	sequence s_acoc_trip_start;
		!sense_i.config_input_oc_trip ##1 st_reg.opt2[`CBOC_B_CFG_IN_OC_EN] &&
			(st_reg.acoc == cboc_pkg::CBOC_ACOC_IDLE) && sense_i.config_input_oc_trip;
	endsequence

	property p_limit_source;
		!st_reg.opt2[`CBOC_B_LIMIT_PIN_SEL] |=>
			input_limit_o == $past(sense_i.programmed_input_limit);
	endproperty
	a_limit_source: assert property (p_limit_source) // RQ1
		else $error("input limit not from programmed value");

	property p_monitor_charge;
		st_reg.opt2[`CBOC_B_MONITOR_POL] |=>
			battery_current_monitor_out_o == $past(sense_i.charge_current);
	endproperty
	a_monitor_charge: assert property (p_monitor_charge) // RQ2
		else $error("monitor not showing charge current");

	property p_low_side_level;
		(low_side_oc_mv_o == `CBOC_LOW_SIDE_OC_LO_MV) |->
			$past(st_reg.opt2[`CBOC_B_LOW_SIDE_OC]);
	endproperty
	a_low_side_level: assert property (p_low_side_level) // RQ3
		else $error("low-side threshold does not follow select bit");

	property p_fixed_trip_stop;
		sense_i.fixed_input_oc_trip |=> !converter_enable_o;
	endproperty
	a_fixed_trip_stop: assert property (p_fixed_trip_stop) // RQ4
		else $error("converter not stopped on fixed input trip");

	property p_acoc_blank_out;
		s_acoc_trip_start |=> !config_input_oc_fault_o [*8];
	endproperty
	a_acoc_blank_out: assert property (p_acoc_blank_out) // RQ5
		else $error("configurable fault raised inside blank-out");

	property p_dchg_trip;
		st_reg.opt2[`CBOC_B_DCHG_OC_EN] && st_reg.opt2[`CBOC_B_DCHG_OC_LVL] &&
			({8'h00, sense_i.discharge_current} >
			{7'h00, sense_i.second_discharge_threshold, 1'b0}) |=>
			discharge_oc_fault_o && !converter_enable_o;
	endproperty
	a_dchg_trip: assert property (p_dchg_trip) // RQ8
		else $error("discharge overcurrent above twice threshold not caught");

	property p_reg_reset;
		s_reset_write |=> register_reset_pulse_o && (st_reg.opt3 == `CBOC_OPT3_RESET) &&
			(st_reg.opt2 == `CBOC_OPT2_RESET) ##1 !register_reset_pulse_o;
	endproperty
	a_reg_reset: assert property (p_reg_reset) // RQ10
		else $error("register reset did not restore defaults once");

	property p_remeasure_stop;
		remeasure_active_o |=> !converter_enable_o;
	endproperty
	a_remeasure_stop: assert property (p_remeasure_stop) // RQ11
		else $error("converter running during remeasure");

	property p_bus_supply;
		bus_supply_mode_o |-> $past(sense_i.shared_mode_control_pin) &&
			$past(st_reg.opt3[`CBOC_B_BUS_SUPPLY]);
	endproperty
	a_bus_supply: assert property (p_bus_supply) // RQ12
		else $error("bus supply mode without bit and pin");

	property p_slew_step;
		st_reg.opt3[`CBOC_B_SOFT_SLEW] && $past(st_reg.opt3[`CBOC_B_SOFT_SLEW]) &&
			$changed(min_system_voltage_o) |->
			((min_system_voltage_o - $past(min_system_voltage_o)) == 8'h01) ||
			(($past(min_system_voltage_o) - min_system_voltage_o) == 8'h01);
	endproperty
	a_slew_step: assert property (p_slew_step) // RQ15
		else $error("minimum voltage moved more than one step");

	property p_opt3_default;
		$past(sys_rst_i) |-> (st_reg.opt3 == `CBOC_OPT3_RESET);
	endproperty
	a_opt3_default: assert property (p_opt3_default) // RQ16
		else $error("third option register not at default after reset");

endmodule : cboc_option_bank

// >>> design/cboc_params.svh
// Purpose: constants of the charger option control bank
// Assumes: 100 MHz system clock, word access by 8-bit command code
// Notes:   offsets, field positions, reset values and timing counts
`ifndef CBOC_PARAMS_SVH
`define CBOC_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define CBOC_ADDR_OPT2 8'h31
`define CBOC_ADDR_OPT3 8'h32
`define CBOC_OPT2_RESET 8'hb7
`define CBOC_OPT3_RESET 16'h0434

// ----------------------------------------
// fields of the second option register (low byte)
// ----------------------------------------
`define CBOC_B_LIMIT_PIN_SEL 7
`define CBOC_B_MONITOR_POL 6
`define CBOC_B_LOW_SIDE_OC 5
`define CBOC_B_FIXED_IN_OC 4
`define CBOC_B_CFG_IN_OC_EN 3
`define CBOC_B_CFG_IN_OC_LVL 2
`define CBOC_B_DCHG_OC_EN 1
`define CBOC_B_DCHG_OC_LVL 0

// ----------------------------------------
// fields of the third option register
// ----------------------------------------
`define CBOC_B_HIGH_IMP 15
`define CBOC_B_REG_RESET 14
`define CBOC_B_REMEASURE 13
`define CBOC_B_BUS_SUPPLY 12
`define CBOC_B_OPTIMIZER 11
`define CBOC_B_SWITCH_CTRL 10
`define CBOC_B_SOFT_SLEW 9

// ----------------------------------------
// thresholds
// ----------------------------------------
`define CBOC_LOW_SIDE_OC_HI_MV 9'h0d2
`define CBOC_LOW_SIDE_OC_LO_MV 9'h096
`define CBOC_FIXED_OC_HI_MV 9'h118
`define CBOC_FIXED_OC_LO_MV 9'h096
`define CBOC_FIXED_OC_ALT_HI_MV 9'h0c8
`define CBOC_FIXED_OC_ALT_LO_MV 9'h064
`define CBOC_PCT_LOW 8'h85
`define CBOC_PCT_HIGH 8'hc8
`define CBOC_PCT_DIVISOR 16'h0064

// ----------------------------------------
// timing
// ----------------------------------------
`define CBOC_CLK_MHZ 100
`define CBOC_ACOC_BLANK_US 250
`define CBOC_ACOC_BLANK_CYC (`CBOC_ACOC_BLANK_US * `CBOC_CLK_MHZ)
`define CBOC_ACOC_RELEASE_MS 250
`define CBOC_ACOC_RELEASE_CYC (`CBOC_ACOC_RELEASE_MS * 1000 * `CBOC_CLK_MHZ)
`define CBOC_SLEW_STEP_US 8
`define CBOC_SLEW_STEP_CYC (`CBOC_SLEW_STEP_US * `CBOC_CLK_MHZ)
`define CBOC_TIMER_W 25

`endif

// >>> design/cboc_pkg.sv
// Purpose: types of the charger option control bank
// Assumes: constants come from cboc_params.svh
// Notes:   carriers for host requests, sensed inputs and module state
`include "cboc_params.svh"

package cboc_pkg;

	// ----------------------------------------
	// configurable input overcurrent states
	// ----------------------------------------
	typedef enum logic [1:0] {
		CBOC_ACOC_IDLE = 2'b00,
		CBOC_ACOC_BLANK = 2'b01,
		CBOC_ACOC_FAULT = 2'b11,
		CBOC_ACOC_RELEASE = 2'b10
	} cboc_acoc_state_t;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] cmd;
		logic [15:0] wdata;
	} cboc_host_req_t;

	typedef struct packed {
		logic [7:0] external_limit_pin;
		logic [7:0] programmed_input_limit;
		logic [7:0] charge_current;
		logic [7:0] discharge_current;
		logic [7:0] second_discharge_threshold;
		logic [7:0] min_system_voltage;
		logic fixed_input_oc_trip;
		logic config_input_oc_trip;
		logic input_sense_resistor_select;
		logic shared_mode_control_pin;
		logic measure_done;
		logic battery_switch_level;
	} cboc_sense_t;

	typedef struct packed {
		logic [`CBOC_TIMER_W-1:0] count;
		logic expired;
	} cboc_interval_state_t;

	typedef struct packed {
		logic [7:0] opt2;
		logic [15:0] opt3;
		cboc_acoc_state_t acoc;
		logic [15:0] rdata;
		logic rd_ack;
		logic [7:0] input_limit;
		logic [7:0] monitor;
		logic [8:0] low_side_mv;
		logic [8:0] fixed_mv;
		logic [7:0] cfg_pct;
		logic converter_en;
		logic cfg_fault;
		logic dchg_fault;
		logic reg_reset_pulse;
		logic bus_supply;
		logic switch_level;
		logic switch_oe_n;
		logic [7:0] min_sys;
	} cboc_bank_state_t;

endpackage : cboc_pkg

// >>> verif/cboc_host_model.sv
// Purpose: host side of the option bank word port
// Assumes: requests change at the falling clock edge
// Notes:   idle lines show inverted last values, never stale ones
`timescale 1ns/1ns

module cboc_host_model (
	input wire logic clk_sys_i,
	input wire logic rd_ack_i,
	input wire logic [15:0] rdata_i,
	output cboc_pkg::cboc_host_req_t host_req_o
);
	initial begin
		host_req_o = '0;
	end

	// ----------------------------------------
	// word transfers
	// ----------------------------------------
	task automatic release_req();
		@(negedge clk_sys_i);
		host_req_o.wr = 1'b0;
		host_req_o.rd = 1'b0;
		host_req_o.cmd = ~host_req_o.cmd;
		host_req_o.wdata = ~host_req_o.wdata;
	endtask : release_req

	task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
		@(negedge clk_sys_i);
		host_req_o.cmd = cmd;
		host_req_o.wdata = data;
		host_req_o.wr = 1'b1;
		release_req();
	endtask : write_word

	task automatic read_word(input logic [7:0] cmd, output logic [15:0] data,
		output logic ok);
		int n;
		ok = 1'b0;
		data = 16'h0000;
		@(negedge clk_sys_i);
		host_req_o.cmd = cmd;
		host_req_o.rd = 1'b1;
		release_req();
		for (n = 0; n < 4 && !ok; n++) begin
			if (rd_ack_i === 1'b1) begin
				data = rdata_i;
				ok = 1'b1;
			end else begin
				@(negedge clk_sys_i);
			end
		end
	endtask : read_word
endmodule : cboc_host_model

// >>> verif/charger_option_control_bank_test.sv
// Purpose: self-checking bench of the option register bank
// Assumes: inputs change at the falling edge, short overcurrent timers
// Notes:   each scenario judges its own outputs
`timescale 1ns/1ns
`include "cboc_params.svh"

module charger_option_control_bank_test;
	logic clk_sys_i = 1'b0;
	logic sys_rst_i = 1'b1;
	cboc_pkg::cboc_host_req_t host_req;
	cboc_pkg::cboc_sense_t sense = '0;
	logic [15:0] rdata;
	logic [8:0] low_side_mv, fixed_mv;
	logic [7:0] input_limit, monitor, cfg_pct, min_sys;
	logic rd_ack, converter_en, cfg_fault, dchg_fault, high_imp, reg_reset_pulse;
	logic remeasure, bus_supply, optimizer, switch_drive, switch_oe_n;
	int errors = 0;
	int checks = 0;

	always #5 clk_sys_i = ~clk_sys_i;

	cboc_option_bank #(.ACOC_BLANK_CYC(8), .ACOC_RELEASE_CYC(20)) dut (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .host_req_i(host_req),
		.sense_i(sense), .rdata_o(rdata), .rd_ack_o(rd_ack), .input_limit_o(input_limit),
		.battery_current_monitor_out_o(monitor), .low_side_oc_mv_o(low_side_mv),
		.fixed_input_oc_mv_o(fixed_mv), .config_input_oc_pct_o(cfg_pct),
		.converter_enable_o(converter_en), .config_input_oc_fault_o(cfg_fault),
		.discharge_oc_fault_o(dchg_fault), .high_impedance_mode_o(high_imp),
		.register_reset_pulse_o(reg_reset_pulse), .remeasure_active_o(remeasure),
		.bus_supply_mode_o(bus_supply), .current_optimizer_run_o(optimizer),
		.battery_switch_drive_o(switch_drive), .battery_switch_drive_oe_n_o(switch_oe_n),
		.min_system_voltage_o(min_sys));

	cboc_host_model host (.clk_sys_i(clk_sys_i), .rd_ack_i(rd_ack), .rdata_i(rdata),
		.host_req_o(host_req));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic report_and_stop();
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : wait_n

	task automatic rd_chk(input logic [7:0] cmd, input logic [15:0] exp);
		logic [15:0] d;
		logic ok;
		host.read_word(cmd, d, ok);
		chk({15'h0000, ok}, 16'h0001);
		chk(d, exp);
	endtask : rd_chk

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_defaults();
		wait_n(3);
		rd_chk(8'h31, 16'h00b7);
		rd_chk(8'h32, 16'h0434);
		rd_chk(8'h33, 16'h0000);
		chk(low_side_mv, `CBOC_LOW_SIDE_OC_LO_MV);
		chk(fixed_mv, `CBOC_FIXED_OC_LO_MV);
		chk(cfg_pct, `CBOC_PCT_HIGH);
		chk(input_limit, 8'h40);
		chk(monitor, 8'h11);
		chk({switch_oe_n, switch_drive}, 16'h0001);
		chk({converter_en, bus_supply, optimizer, high_imp}, 16'h0008);
	endtask : t_defaults

	task automatic t_option_two();
		host.write_word(8'h31, 16'h0040);
		wait_n(3);
		chk(input_limit, 8'h50);
		chk(monitor, 8'h22);
		chk(low_side_mv, `CBOC_LOW_SIDE_OC_HI_MV);
		chk(fixed_mv, `CBOC_FIXED_OC_HI_MV);
		chk(cfg_pct, `CBOC_PCT_LOW);
		sense.input_sense_resistor_select = 1'b1;
		sense.discharge_current = 8'h7f;
		wait_n(3);
		chk(fixed_mv, `CBOC_FIXED_OC_ALT_HI_MV);
		chk({dchg_fault, converter_en}, 16'h0001);
		host.write_word(8'h31, 16'h0002);
		wait_n(3);
		chk({dchg_fault, converter_en}, 16'h0002);
		sense.discharge_current = 8'h3f;
		wait_n(3);
		chk(dchg_fault, 1'b0);
		sense.discharge_current = 8'h40;
		wait_n(3);
		chk(dchg_fault, 1'b1);
		host.write_word(8'h31, 16'h0003);
		sense.discharge_current = 8'h60;
		wait_n(3);
		chk(dchg_fault, 1'b0);
		sense.discharge_current = 8'h61;
		wait_n(3);
		chk(dchg_fault, 1'b1);
		sense.discharge_current = 8'h11;
		sense.input_sense_resistor_select = 1'b0;
		host.write_word(8'h31, 16'h00b7);
	endtask : t_option_two

	task automatic t_input_oc();
		sense.fixed_input_oc_trip = 1'b1;
		wait_n(3);
		chk(converter_en, 1'b0);
		sense.fixed_input_oc_trip = 1'b0;
		wait_n(3);
		chk(converter_en, 1'b1);
		host.write_word(8'h31, 16'h00bf);
		sense.config_input_oc_trip = 1'b1;
		wait_n(4);
		chk({cfg_fault, converter_en}, 16'h0001);
		wait_n(12);
		chk({cfg_fault, converter_en}, 16'h0002);
		sense.config_input_oc_trip = 1'b0;
		wait_n(10);
		chk(cfg_fault, 1'b1);
		wait_n(16);
		chk({cfg_fault, converter_en}, 16'h0001);
		host.write_word(8'h31, 16'h00b7);
	endtask : t_input_oc

	task automatic t_option_three();
		host.write_word(8'h32, 16'h9800);
		wait_n(3);
		chk({high_imp, converter_en}, 16'h0002);
		chk({optimizer, bus_supply, switch_oe_n}, 16'h0005);
		rd_chk(8'h32, 16'h9800);
		sense.shared_mode_control_pin = 1'b1;
		wait_n(3);
		chk(bus_supply, 1'b1);
		host.write_word(8'h32, 16'h0434);
		wait_n(3);
		chk({bus_supply, optimizer, switch_oe_n, switch_drive}, 16'h0001);
		chk({high_imp, converter_en}, 16'h0001);
		sense.battery_switch_level = 1'b0;
		sense.shared_mode_control_pin = 1'b0;
		wait_n(3);
		chk({switch_oe_n, switch_drive}, 16'h0000);
		sense.battery_switch_level = 1'b1;
	endtask : t_option_three

	task automatic t_reg_reset();
		int n;
		n = 0;
		host.write_word(8'h31, 16'h0040);
		host.write_word(8'h32, 16'h8000);
		host.write_word(8'h32, 16'h4000);
		repeat (4) begin
			n += int'(reg_reset_pulse === 1'b1);
			@(negedge clk_sys_i);
		end
		chk(16'(n), 16'h0001);
		rd_chk(8'h31, 16'h00b7);
		rd_chk(8'h32, 16'h0434);
		chk(high_imp, 1'b0);
	endtask : t_reg_reset

	task automatic t_remeasure();
		host.write_word(8'h32, 16'h2434);
		wait_n(3);
		chk({remeasure, converter_en}, 16'h0002);
		rd_chk(8'h32, 16'h2434);
		sense.measure_done = 1'b1;
		@(negedge clk_sys_i);
		sense.measure_done = 1'b0;
		wait_n(3);
		chk({remeasure, converter_en}, 16'h0001);
		rd_chk(8'h32, 16'h0434);
	endtask : t_remeasure

	task automatic t_slew();
		host.write_word(8'h32, 16'h0634);
		wait_n(3);
		chk(min_sys, 8'h20);
		sense.min_system_voltage = 8'h22;
		wait_n(5);
		chk(min_sys, 8'h20);
		wait_n(820);
		chk(min_sys, 8'h21);
		wait_n(900);
		chk(min_sys, 8'h22);
		host.write_word(8'h32, 16'h0434);
		sense.min_system_voltage = 8'h10;
		wait_n(3);
		chk(min_sys, 8'h10);
	endtask : t_slew

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		sense.external_limit_pin = 8'h40;
		sense.programmed_input_limit = 8'h50;
		sense.charge_current = 8'h22;
		sense.discharge_current = 8'h11;
		sense.second_discharge_threshold = 8'h30;
		sense.min_system_voltage = 8'h20;
		sense.battery_switch_level = 1'b1;
		repeat (6) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
		sys_rst_i = 1'b0;
		t_defaults();
		t_option_two();
		t_input_oc();
		t_option_three();
		t_reg_reset();
		t_remeasure();
		t_slew();
		report_and_stop();
	end

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		errors++;
		report_and_stop();
	end
endmodule : charger_option_control_bank_test
